// ==== shared/ldrs_pkg.sv ====
// constants, codes and carrier types of the led driver reset and output stage
package ldrs_pkg;

	localparam int NCH = 8;
	localparam int DUTY_W = 8;

	// register byte offsets on the apb slave
	localparam logic [7:0] ADDR_MODE = 8'h00;
	localparam logic [7:0] ADDR_CHSEL = 8'h04;
	localparam logic [7:0] ADDR_DUTY_LO = 8'h08;
	localparam logic [7:0] ADDR_DUTY_HI = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;

	// field positions
	localparam int MODE_INV_BIT = 0;
	localparam int MODE_DRV_BIT = 1;
	localparam int MODE_DOL_LSB = 2;
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_ARMED_BIT = 2;
	localparam int STAT_OE_BIT = 3;
	localparam int STAT_COUNT_LSB = 8;

	// reset values: everything zero, no channel selected
	localparam logic [3:0] MODE_RST = 4'h0;
	localparam logic [2*NCH-1:0] CHSEL_RST = 16'h0000;
	localparam logic [DUTY_W*NCH-1:0] DUTY_RST = 64'h0000_0000_0000_0000;
	localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

	// software reset call byte values
	localparam logic [7:0] SW_RESET_CALL_ADDR_BYTE = 8'h06;
	localparam logic [7:0] SW_RESET_CALL_KEY_ONE = 8'hA5;
	localparam logic [7:0] SW_RESET_CALL_KEY_TWO = 8'h5A;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [1:0] LAST_KEY_IDX = 2'h2;

	// channel state codes
	localparam logic [1:0] CH_OFF = 2'h0;
	localparam logic [1:0] CH_ON = 2'h1;
	localparam logic [1:0] CH_PWM = 2'h2;
	localparam logic [1:0] CH_GRP = 2'h3;

	// disabled output level codes
	localparam logic [1:0] DOL_LOW = 2'h0;
	localparam logic [1:0] DOL_HIGH = 2'h1;
	localparam logic [1:0] DOL_HIZ = 2'h2;

	// timing: bus free time, longest time so rounded down
	localparam int CLK_PERIOD_NS = 8;
	localparam int T_BUF_NS = 500;
	localparam int T_BUF_CYC = T_BUF_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RECV = 2'b01,
		ST_ACK = 2'b11,
		ST_SKIP = 2'b10
	} ldrs_i2c_st_t;

	typedef struct packed {
		logic [1:0] disabled_output_level;
		logic output_drive_type;
		logic output_invert;
	} ldrs_mode_t;

	typedef struct packed {
		logic [NCH-1:0] upper;
		logic [NCH-1:0] lower;
	} ldrs_drive_t;

endpackage : ldrs_pkg

// ==== verilog/ldrs_out_stage.sv ====
// per-channel transistor control from state, invert, drive type and enable
`timescale 1ns/10ps
module ldrs_out_stage (
	input wire ldrs_pkg::ldrs_mode_t mode,
	input wire logic oe_n,
	input wire logic [2*ldrs_pkg::NCH-1:0] channel_state_select,
	input wire logic [ldrs_pkg::DUTY_W*ldrs_pkg::NCH-1:0] channel_duty,
	input wire logic [ldrs_pkg::DUTY_W-1:0] ind_phase,
	input wire logic grp_wave,
	output ldrs_pkg::ldrs_drive_t next_drive
);
	import ldrs_pkg::*;

	function automatic logic pwm_on(input logic [DUTY_W-1:0] duty,
		input logic [DUTY_W-1:0] phase);
		pwm_on = duty > phase;
	endfunction : pwm_on

	always_comb begin
		logic act;
		logic level;
		logic [1:0] sel;
		logic [DUTY_W-1:0] duty;
		act = 1'b0;
		level = 1'b0;
		sel = CH_OFF;
		duty = '0;
		next_drive = '0;
		for (int i = 0; i < NCH; i++) begin
			sel = channel_state_select[2*i +: 2];
			duty = channel_duty[DUTY_W*i +: DUTY_W];
			if (oe_n) begin
				// only the disabled level counts here, plus the drive type for the high level
				unique case (mode.disabled_output_level)
					DOL_LOW: next_drive.lower[i] = 1'b1;
					DOL_HIGH: next_drive.upper[i] = mode.output_drive_type;
					default: next_drive.lower[i] = 1'b0;
				endcase
			end else begin
				unique case (sel)
					CH_OFF: act = 1'b0;
					CH_ON: act = 1'b1;
					CH_PWM: act = pwm_on(duty, ind_phase);
					CH_GRP: act = pwm_on(duty, ind_phase) & grp_wave;
				endcase
				level = act ^ mode.output_invert;
				// lower sinks when active xor invert; upper sources only in totem-pole
				next_drive.lower[i] = level;
				next_drive.upper[i] = mode.output_drive_type & ~level;
			end
		end
	end

endmodule : ldrs_out_stage

// ==== verilog/ldrs_top.sv ====
// led driver reset logic, software reset call receiver and output control
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/10ps
module ldrs_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic oe_n,
	input wire logic [ldrs_pkg::DUTY_W-1:0] ind_phase,
	input wire logic grp_wave,
	output logic [ldrs_pkg::NCH-1:0] channel_upper,
	output logic [ldrs_pkg::NCH-1:0] channel_lower,
	output logic sw_reset_call
);
	import ldrs_pkg::*;

	// pin synchronisers: bit 0 scl, bit 1 sda, bit 2 output enable
	logic [2:0] sync_a;
	logic [2:0] sync_b;
	logic scl_d;
	logic sda_d;
	logic scl_s;
	logic sda_s;
	logic oe_s;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	ldrs_i2c_st_t st;
	logic [3:0] bit_cnt;
	logic [7:0] shreg;
	logic [1:0] byte_idx;
	logic armed;
	logic [7:0] sw_reset_call_count;

	ldrs_mode_t mode;
	logic [2*NCH-1:0] channel_state_select;
	logic [DUTY_W*NCH-1:0] channel_duty;
	ldrs_drive_t next_drive;

	logic setup_ph;
	logic wr_en;
	logic [31:0] next_prdata;
	logic next_pslverr;

	function automatic logic ack_ok(input logic [1:0] idx,
		input logic [7:0] b);
		unique case (idx)
			2'h0: ack_ok = b == SW_RESET_CALL_ADDR_BYTE;
			2'h1: ack_ok = b == SW_RESET_CALL_KEY_ONE;
			2'h2: ack_ok = b == SW_RESET_CALL_KEY_TWO;
			2'h3: ack_ok = 1'b0;
		endcase
	endfunction : ack_ok

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_a <= 3'h7;
			sync_b <= 3'h7;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			sync_a <= {oe_n, sda_in, scl_in};
			sync_b <= sync_a;
			scl_d <= sync_b[0];
			sda_d <= sync_b[1];
		end
	end

	assign scl_s = sync_b[0];
	assign sda_s = sync_b[1];
	assign oe_s = sync_b[2];
	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign start_det = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_det = scl_s & scl_d & ~sda_d & sda_s;

	// reset call receiver; any refused byte parks it until start or stop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= ST_IDLE;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			byte_idx <= 2'h0;
			armed <= 1'b0;
			sda_oe <= 1'b0;
		end else if (start_det) begin
			st <= ST_RECV;
			bit_cnt <= 4'h0;
			byte_idx <= 2'h0;
			armed <= 1'b0;
			sda_oe <= 1'b0;
		end else if (stop_det) begin
			st <= ST_IDLE;
			armed <= 1'b0;
			sda_oe <= 1'b0;
		end else begin
			unique case (st)
				ST_IDLE: st <= ST_IDLE;
				ST_RECV: begin
					if (scl_rise && bit_cnt != BITS_PER_BYTE) begin
						shreg <= {shreg[6:0], sda_s};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
						if (ack_ok(byte_idx, shreg)) begin
							st <= ST_ACK;
							sda_oe <= 1'b1;
						end else begin
							st <= ST_SKIP;
							armed <= 1'b0;
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						st <= ST_RECV;
						sda_oe <= 1'b0;
						bit_cnt <= 4'h0;
						if (byte_idx == LAST_KEY_IDX) begin
							armed <= 1'b1;
						end
						if (byte_idx != 2'h3) begin
							byte_idx <= byte_idx + 2'h1;
						end
					end
				end
				ST_SKIP: st <= ST_SKIP;
			endcase
		end
	end

	// the pin only ever pulls low; the enable carries the acknowledge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sda_out <= 1'b0;
		end else begin
			sda_out <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_reset_call <= 1'b0;
			sw_reset_call_count <= 8'h00;
		end else begin
			sw_reset_call <= stop_det & armed;
			if (stop_det && armed) begin
				sw_reset_call_count <= sw_reset_call_count + 8'h01;
			end
		end
	end

	// register file; the call reset wins over a write in the same cycle
	assign setup_ph = psel & ~penable;
	assign wr_en = psel & penable & pwrite & pready;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode <= MODE_RST;
			channel_state_select <= CHSEL_RST;
			channel_duty <= DUTY_RST;
		end else if (sw_reset_call) begin
			mode <= MODE_RST;
			channel_state_select <= CHSEL_RST;
			channel_duty <= DUTY_RST;
		end else if (wr_en) begin
			unique case (paddr)
				ADDR_MODE: mode <= pwdata[3:0];
				ADDR_CHSEL: channel_state_select <= pwdata[2*NCH-1:0];
				ADDR_DUTY_LO: channel_duty[31:0] <= pwdata;
				ADDR_DUTY_HI: channel_duty[63:32] <= pwdata;
				default: mode <= mode;
			endcase
		end
	end

	always_comb begin
		next_prdata = RDATA_ZERO;
		next_pslverr = 1'b0;
		unique case (paddr)
			ADDR_MODE: next_prdata[3:0] = mode;
			ADDR_CHSEL: next_prdata[2*NCH-1:0] = channel_state_select;
			ADDR_DUTY_LO: next_prdata = channel_duty[31:0];
			ADDR_DUTY_HI: next_prdata = channel_duty[63:32];
			ADDR_STATUS: begin
				next_prdata[STAT_STATE_LSB +: 2] = st;
				next_prdata[STAT_ARMED_BIT] = armed;
				next_prdata[STAT_OE_BIT] = oe_s;
				next_prdata[STAT_COUNT_LSB +: 8] = sw_reset_call_count;
			end
			default: next_pslverr = 1'b1;
		endcase
	end

	// one access cycle per transfer: answer is prepared in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= RDATA_ZERO;
		end else begin
			pready <= setup_ph;
			pslverr <= setup_ph & next_pslverr;
			if (setup_ph) begin
				prdata <= pwrite ? RDATA_ZERO : next_prdata;
			end
		end
	end

	ldrs_out_stage u_out_stage (
		.mode(mode),
		.oe_n(oe_s),
		.channel_state_select(channel_state_select),
		.channel_duty(channel_duty),
		.ind_phase(ind_phase),
		.grp_wave(grp_wave),
		.next_drive(next_drive)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			channel_upper <= '0;
			channel_lower <= '0;
		end else begin
			channel_upper <= next_drive.upper;
			channel_lower <= next_drive.lower;
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_byte_end;
		st == ST_RECV && scl_fall && bit_cnt == BITS_PER_BYTE;
	endsequence

	sequence s_call_done;
		stop_det && armed;
	endsequence

	a_addr_ack_only: assert property (
		s_byte_end and byte_idx == 2'h0 |=>
			sda_oe == ($past(shreg) == SW_RESET_CALL_ADDR_BYTE))
		else $error("address byte acknowledge wrong");

	a_key_one_ack: assert property (
		s_byte_end and byte_idx == 2'h1 |=>
			sda_oe == ($past(shreg) == SW_RESET_CALL_KEY_ONE))
		else $error("first key acknowledge wrong");

	a_key_two_ack: assert property (
		s_byte_end and byte_idx == 2'h2 |=>
			sda_oe == ($past(shreg) == SW_RESET_CALL_KEY_TWO))
		else $error("second key acknowledge wrong");

	a_extra_byte_nack: assert property (
		s_byte_end and byte_idx == 2'h3 |=> !sda_oe ##0 st == ST_SKIP)
		else $error("byte after second key acknowledged");

	a_call_restores: assert property (
		s_call_done |=> sw_reset_call ##1 mode == MODE_RST &&
			channel_state_select == CHSEL_RST && channel_duty == DUTY_RST)
		else $error("reset call did not restore registers");

	a_call_only_valid: assert property (
		sw_reset_call |-> $past(stop_det) && $past(armed))
		else $error("reset without a valid call");

	a_disabled_low: assert property (
		oe_s && mode.disabled_output_level == DOL_LOW |=>
			channel_lower == '1 && channel_upper == '0)
		else $error("disabled low level wrong");

	a_disabled_high: assert property (
		oe_s && mode.disabled_output_level != DOL_LOW |=>
			channel_lower == '0 && channel_upper ==
			{NCH{$past(mode.disabled_output_level) == DOL_HIGH &&
			$past(mode.output_drive_type)}})
		else $error("disabled high or hi-z level wrong");

	a_off_invert: assert property (
		!oe_s && channel_state_select[1:0] == CH_OFF |=>
			channel_lower[0] == $past(mode.output_invert) &&
			channel_upper[0] == ($past(mode.output_drive_type) &&
			!$past(mode.output_invert)))
		else $error("off state transistors wrong");

	a_on_state: assert property (
		!oe_s && channel_state_select[1:0] == CH_ON |=>
			channel_lower[0] == !$past(mode.output_invert))
		else $error("on state transistors wrong");

	a_pwm_open_drain: assert property (
		!oe_s && channel_state_select[1] && !mode.output_drive_type |=>
			!channel_upper[0])
		else $error("upper transistor on in open-drain pwm");

	a_group_gate: assert property (
		!oe_s && channel_state_select[1:0] == CH_GRP && !grp_wave |=>
			channel_lower[0] == $past(mode.output_invert))
		else $error("group wave did not gate channel");

	a_por_clear: assert property (
		$rose(presetn) |-> mode == MODE_RST && st == ST_IDLE &&
			channel_state_select == CHSEL_RST)
		else $error("power-on state not cleared");

endmodule : ldrs_top

// ==== sim/ldrs_i2c_master.sv ====
// serial bus master model that issues reset calls on an open-drain line
`timescale 1ns/10ps
module ldrs_i2c_master (
	input wire logic sda_bus,
	output logic scl,
	output logic sda_drv
);
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	// data moves only while scl is low, so no false start or stop is seen
	task automatic bit_out(input logic b);
		#8 sda_drv = b;
		#24 scl = 1'b1;
		#32 scl = 1'b0;
	endtask : bit_out
	task automatic call(input logic [31:0] seq, input int n, output int acks);
		logic ack;
		acks = 0;
		// step off the pclk edges so no pin moves as it is sampled
		#2;
		#8 sda_drv = 1'b1;
		#24 scl = 1'b1;
		#32 sda_drv = 1'b0;
		#32 scl = 1'b0;
		for (int i = 0; i < n; i++) begin
			for (int j = 0; j < 8; j++) bit_out(seq[31 - 8 * i - j]);
			#8 sda_drv = 1'b1;
			#24 scl = 1'b1;
			#16 ack = ~sda_bus;
			#16 scl = 1'b0;
			if (ack !== 1'b1) break;
			acks++;
		end
		#8 sda_drv = 1'b0;
		#24 scl = 1'b1;
		#32 sda_drv = 1'b1;
		#64;
	endtask : call
endmodule : ldrs_i2c_master

// ==== sim/ldrs_top_tb.sv ====
// self-checking bench for the led driver reset and output stage
`timescale 1ns/10ps
module ldrs_top_tb;
	import ldrs_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic oe_n = 1'b1;
	logic [7:0] ind_phase = 8'h00;
	logic grp_wave = 1'b0;
	logic [31:0] prdata, rd, d;
	logic pready, pslverr, sda_out, sda_oe, scl, sda_m, sw_reset_call, err;
	logic [7:0] channel_upper, channel_lower;
	wire logic sda_in;
	wire logic [15:0] drv;
	int seed = 55766;
	int miscompares = 0;
	int checks_done = 0;
	int pulses = 0;
	int a, p, acks, tot;
	logic [31:0] msk [4] = '{32'h0000_000F, 32'h0000_FFFF, '1, '1};
	logic [31:0] seq [7] = '{32'h06A5_5A00, 32'h0700_0000, 32'h06A4_0000,
		32'h06A5_5B00, 32'h06A5_5A00, 32'h0000_0000, 32'h06A5_5A00};
	int nb [7] = '{3, 1, 2, 3, 4, 1, 3};
	int na [7] = '{3, 0, 1, 2, 3, 0, 3};
	bit rs [7] = '{1, 0, 0, 0, 0, 0, 1};
	// pulled-up wire: low whenever either side pulls it
	assign sda_in = sda_m & ~(sda_oe & ~sda_out);
	assign drv = {channel_upper, channel_lower};
	always #4 pclk = ~pclk;
	always @(posedge pclk) if (sw_reset_call === 1'b1) pulses++;
	ldrs_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .scl_in(scl), .sda_in,
		.sda_out, .sda_oe, .oe_n, .ind_phase, .grp_wave, .channel_upper,
		.channel_lower, .sw_reset_call);
	ldrs_i2c_master mst_u (.sda_bus(sda_in), .scl(scl), .sda_drv(sda_m));
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk32(input string nm, input logic [31:0] e, g);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk32
	task automatic chk16(input string nm, input logic [15:0] e, g);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk16
	task automatic apb(input logic w, input logic [7:0] ad,
		input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// the slave answers in the first access cycle
		chk16("pready wait", 16'h1, 16'(n));
	endtask : apb
	function automatic logic [15:0] exp_drv(input logic [3:0] m,
		input logic oen, input logic [15:0] cs, input logic [63:0] du,
		input logic [7:0] ph, input logic g);
		logic [7:0] up, lo;
		logic act;
		up = '0;
		lo = '0;
		for (int c = 0; c < 8; c++) begin
			act = du[8*c+:8] > ph;
			case (cs[2*c+:2])
				2'h0: act = 1'b0;
				2'h1: act = 1'b1;
				2'h3: act = act & g;
				default: ;
			endcase
			lo[c] = oen ? m[3:2] == 2'h0 : act ^ m[0];
			up[c] = oen ? m[3:2] == 2'h1 && m[1] : m[1] & ~lo[c];
		end
		return {up, lo};
	endfunction : exp_drv
	task automatic out_case(input logic [3:0] m, input logic [15:0] cs,
		input logic [63:0] du, input logic on);
		logic [15:0] e;
		apb(1'b1, ADDR_MODE, {28'h0, m});
		apb(1'b1, ADDR_CHSEL, {16'h0, cs});
		apb(1'b1, ADDR_DUTY_LO, du[31:0]);
		apb(1'b1, ADDR_DUTY_HI, du[63:32]);
		@(posedge pclk);
		oe_n <= on;
		ind_phase <= 8'($random(seed));
		grp_wave <= 1'($random(seed));
		repeat (5) @(posedge pclk);
		e = exp_drv(m, oe_n, cs, du, ind_phase, grp_wave);
		chk16("out", e, drv);
	endtask : out_case
	initial begin
		#200_000;
		miscompares++;
		report_and_stop();
	end
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, 8'(4 * i), 32'h0);
			chk32("reset", 32'h0, rd);
		end
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk32("status", 32'h0000_0008, rd);
		chk16("out", 16'h00FF, drv);
		apb(1'b1, 8'h14, 32'hFFFF_FFFF);
		chk32("slverr", 32'h1, {31'h0, err});
		$display("test reset done");
		for (int i = 0; i < 12; i++) begin
			a = $random(seed) & 3;
			d = $random(seed);
			apb(1'b1, 8'(4 * a), d);
			apb(1'b0, 8'(4 * a), 32'h0);
			chk32("reg", d & msk[a], rd);
		end
		$display("test registers done");
		// every state code on two channels each, all modes, both enables
		for (int k = 0; k < 32; k++) begin
			out_case(4'(k), 16'hE4E4, {$random(seed), $random(seed)}, k[4]);
		end
		for (int k = 0; k < 24; k++) begin
			d = $random(seed);
			out_case(d[3:0], d[31:16], {$random(seed), $random(seed)}, d[4]);
		end
		$display("test outputs done");
		seq[5] = {8'($random(seed)) | 8'h10, 24'h0};
		tot = 0;
		for (int i = 0; i < 7; i++) begin
			for (int j = 0; j < 3; j++) apb(1'b1, 8'(4 * j), 32'h0000_0005);
			p = pulses;
			mst_u.call(seq[i], nb[i], acks);
			repeat (4) @(posedge pclk);
			chk16("acks", 16'(na[i]), 16'(acks));
			chk16("pulse", 16'(rs[i]), 16'(pulses - p));
			for (int j = 0; j < 3; j++) begin
				apb(1'b0, 8'(4 * j), 32'h0);
				chk32("regs", rs[i] ? 32'h0 : 32'h0000_0005, rd);
			end
			tot += rs[i];
			$display("test call %0d done", i);
		end
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk32("calls", 32'(tot), {24'h0, rd[15:8]});
		report_and_stop();
	end
endmodule : ldrs_top_tb
